// *** verilog/nism_top.sv ***
// Interrupt cause flags, enable mask and interrupt output of the network controller
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
`include "nism_defines.svh"

module nism_top
    import nism_pkg::*;
(
    // Clock and reset
    input  wire logic                    i_clk,
    input  wire logic                    i_srst,
    // Register bus
    input  wire nism_bus_req_type        i_bus,
    output logic [`NISM_DATA_W-1:0]      o_rdata,
    // Event sources
    input  wire nism_events_type         i_events,
    input  wire logic [`NISM_TALLY_N-1:0] i_tally_msb,
    input  wire logic [`NISM_PTR_W-1:0]  i_local_dma_ptr,
    input  wire logic [`NISM_PTR_W-1:0]  i_boundary_ptr,
    // Interrupt and status view
    output logic                         o_irq,
    output logic [`NISM_DATA_W-1:0]      o_flags
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    logic [`NISM_DATA_W-1:0]  flags;
    logic [`NISM_DATA_W-1:0]  mask;
    logic [`NISM_TALLY_N-1:0] tally_prev;
    logic                     ring_prev;
    logic                     irq;
    logic [`NISM_DATA_W-1:0]  rdata;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    wire logic wr_flags;
    wire logic wr_mask;
    wire logic rd_flags;

    // Strobes qualified by address; the mask is write-only
    assign wr_flags = i_bus.wr && (i_bus.addr == `NISM_FLAGS_ADDR);
    assign wr_mask  = i_bus.wr && (i_bus.addr == `NISM_MASK_ADDR);
    assign rd_flags = i_bus.rd && (i_bus.addr == `NISM_FLAGS_ADDR);

    // ------------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------------
    wire logic       ring_hit;
    wire logic       ring_rise;
    wire logic       tally_rise;
    wire logic       rx_fault;
    wire logic       tx_fault;
    wire logic [6:0] set_vec;
    wire logic [6:0] clr_vec;

    // Pointer meeting is a level; only its arrival is an event
    assign ring_hit   = (i_local_dma_ptr == i_boundary_ptr);
    assign ring_rise  = ring_hit && !ring_prev;
    // Any counter whose top bit rises counts, several at once give one event
    assign tally_rise = |(i_tally_msb & ~tally_prev);
    assign rx_fault   = i_events.crc_error | i_events.align_error
                      | i_events.fifo_overrun | i_events.missed_packet;
    assign tx_fault   = i_events.excess_collisions | i_events.fifo_underrun;

    // Set vector in flag order
    assign set_vec[`NISM_RX_GOOD_BIT]   = i_events.rx_ok;
    assign set_vec[`NISM_TX_GOOD_BIT]   = i_events.tx_ok;
    assign set_vec[`NISM_RX_FAULT_BIT]  = rx_fault;
    assign set_vec[`NISM_TX_FAULT_BIT]  = tx_fault;
    assign set_vec[`NISM_RING_FULL_BIT] = ring_rise;
    assign set_vec[`NISM_TALLY_BIT]     = tally_rise;
    assign set_vec[`NISM_DMA_DONE_BIT]  = i_events.host_dma_done;

    // Write-one-to-clear; bit 7 is outside the clear vector
    assign clr_vec = wr_flags ? i_bus.wdata[6:0] : 7'h00;

    // ------------------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------------------
    wire logic                    rst_set;
    wire logic                    rst_clr;
    wire logic [6:0]              next_src;
    wire logic                    next_rst_bit;
    wire logic [`NISM_DATA_W-1:0] next_flags;
    wire logic [`NISM_DATA_W-1:0] next_mask;
    wire logic                    next_irq;
    wire logic [`NISM_DATA_W-1:0] next_rdata;

    // Set is ORed in last so a coincident clear cannot swallow an event
    assign next_src     = (flags[6:0] & ~clr_vec) | set_vec;
    // Reset indicator: stop or overflow sets, start or removal clears
    assign rst_set      = i_events.stop_cmd | i_events.ring_overflow;
    assign rst_clr      = i_events.start_cmd | i_events.packet_removed;
    assign next_rst_bit = rst_set | (flags[`NISM_RESET_BIT] & ~rst_clr);
    assign next_flags   = {next_rst_bit, next_src};
    // Reserved mask bit is forced to zero
    assign next_mask    = wr_mask ? (i_bus.wdata & `NISM_SRC_BITS) : mask;
    // Only the seven source bits reach the interrupt
    assign next_irq     = |(next_src & next_mask[6:0]);
    // Read data stands one cycle only, zero otherwise and for unmapped reads
    assign next_rdata   = rd_flags ? flags : `NISM_READ_IDLE;

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Reset puts the block in its reset state, so the indicator comes up set
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            flags      <= `NISM_FLAGS_RESET;
            mask       <= `NISM_MASK_RESET;
            tally_prev <= '0;
            ring_prev  <= 1'b1;
            irq        <= 1'b0;
            rdata      <= `NISM_READ_IDLE;
        end else begin
            flags      <= next_flags;
            mask       <= next_mask;
            tally_prev <= i_tally_msb;
            ring_prev  <= ring_hit;
            irq        <= next_irq;
            rdata      <= next_rdata;
        end
    end

    // Outputs come straight from flip-flops
    assign o_irq   = irq;
    assign o_flags = flags;
    assign o_rdata = rdata;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    wire logic any_set;
    assign any_set = |set_vec;

    // A clearing write with no competing event
    sequence s_quiet_clear;
        wr_flags && !any_set;
    endsequence

    // A clear and a set of the same bit meeting in one cycle
    sequence s_clash;
        wr_flags && |(clr_vec & set_vec);
    endsequence

    // Written ones fall, written zeros stay
    clear_one_a: assert property (
        s_quiet_clear |=> flags[6:0] == ($past(flags[6:0]) & ~$past(i_bus.wdata[6:0])))
        else $error("write-one clear did not act");

    zero_keep_a: assert property (
        wr_flags |=> (($past(flags[6:0]) & ~$past(i_bus.wdata[6:0])) & ~flags[6:0]) == 7'h00)
        else $error("flag lost on zero write");

    // Interrupt tied to enabled flags in every cycle
    irq_level_a: assert property (
        o_irq == |(flags[6:0] & mask[6:0]))
        else $error("interrupt disagrees with enabled flags");

    irq_hold_a: assert property (
        (o_irq && !wr_flags && !wr_mask) |=> o_irq)
        else $error("interrupt dropped without a clear");

    rx_good_a: assert property (
        i_events.rx_ok |=> flags[`NISM_RX_GOOD_BIT])
        else $error("rx good flag not set");

    tx_good_a: assert property (
        i_events.tx_ok |=> flags[`NISM_TX_GOOD_BIT])
        else $error("tx good flag not set");

    rx_fault_a: assert property (
        (i_events.crc_error || i_events.align_error || i_events.fifo_overrun
            || i_events.missed_packet) |=> flags[`NISM_RX_FAULT_BIT])
        else $error("rx fault flag not set");

    tx_fault_a: assert property (
        (i_events.excess_collisions || i_events.fifo_underrun) |=> flags[`NISM_TX_FAULT_BIT])
        else $error("tx fault flag not set");

    ring_full_a: assert property (
        (ring_hit && !$past(ring_hit) && !$past(i_srst)) |=> flags[`NISM_RING_FULL_BIT])
        else $error("ring full warning not set");

    tally_over_a: assert property (
        (|(i_tally_msb & ~$past(i_tally_msb))) |=> flags[`NISM_TALLY_BIT])
        else $error("tally overflow flag not set");

    dma_done_a: assert property (
        i_events.host_dma_done |=> flags[`NISM_DMA_DONE_BIT])
        else $error("host dma done flag not set");

    reset_entry_a: assert property (
        $fell(i_srst) |-> flags[`NISM_RESET_BIT])
        else $error("reset indicator clear after reset");

    start_clear_a: assert property (
        (i_events.start_cmd && !rst_set) |=> !flags[`NISM_RESET_BIT])
        else $error("start did not clear reset indicator");

    overflow_set_a: assert property (
        i_events.ring_overflow |=> flags[`NISM_RESET_BIT])
        else $error("overflow did not set reset indicator");

    removed_clear_a: assert property (
        (i_events.packet_removed && !rst_set) |=> !flags[`NISM_RESET_BIT])
        else $error("removal did not clear reset indicator");

    rst_nowrite_a: assert property (
        (wr_flags && !rst_set && !rst_clr) |=> $stable(flags[`NISM_RESET_BIT]))
        else $error("write changed reset indicator");

    mask_write_a: assert property (
        wr_mask |=> (mask[6:0] == $past(i_bus.wdata[6:0])) && !mask[`NISM_RESET_BIT])
        else $error("mask write not taken");

    set_wins_a: assert property (
        s_clash |=> (flags[6:0] & $past(clr_vec & set_vec)) == $past(clr_vec & set_vec))
        else $error("event lost to coincident clear");

endmodule

// *** verilog/nism_defines.svh ***
// Register offsets, field positions, reset values and widths of the interrupt status and mask block
`ifndef NISM_DEFINES_SVH
`define NISM_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register bus geometry
// ----------------------------------------------------------------------------
`define NISM_ADDR_W        4
`define NISM_DATA_W        8
`define NISM_FLAGS_ADDR    4'h7
`define NISM_MASK_ADDR     4'hF

// ----------------------------------------------------------------------------
// Flag and enable bit positions
// ----------------------------------------------------------------------------
`define NISM_RX_GOOD_BIT   0
`define NISM_TX_GOOD_BIT   1
`define NISM_RX_FAULT_BIT  2
`define NISM_TX_FAULT_BIT  3
`define NISM_RING_FULL_BIT 4
`define NISM_TALLY_BIT     5
`define NISM_DMA_DONE_BIT  6
`define NISM_RESET_BIT     7

// ----------------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------------
`define NISM_FLAGS_RESET   8'h80
`define NISM_MASK_RESET    8'h00
`define NISM_SRC_BITS      8'h7F
`define NISM_READ_IDLE     8'h00

// ----------------------------------------------------------------------------
// Source widths
// ----------------------------------------------------------------------------
`define NISM_PTR_W         8
`define NISM_TALLY_N       3

`endif

// *** verilog/nism_pkg.sv ***
// Types shared by the interrupt status and mask block
`include "nism_defines.svh"

package nism_pkg;

    // ------------------------------------------------------------------------
    // Register bus request from the host
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`NISM_ADDR_W-1:0] addr;
        logic [`NISM_DATA_W-1:0] wdata;
        logic                    wr;
        logic                    rd;
    } nism_bus_req_type;

    // ------------------------------------------------------------------------
    // One-cycle event pulses from the receive, transmit and DMA paths and the start and stop commands
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic rx_ok;
        logic crc_error;
        logic align_error;
        logic fifo_overrun;
        logic missed_packet;
        logic tx_ok;
        logic excess_collisions;
        logic fifo_underrun;
        logic host_dma_done;
        logic ring_overflow;
        logic packet_removed;
        logic start_cmd;
        logic stop_cmd;
    } nism_events_type;

endpackage

// *** verif/nism_top_test.sv ***
// Self-checking testbench for the interrupt cause flags, enable mask and interrupt output
`timescale 1ns/100ps
`include "nism_defines.svh"

`define CHECK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s expected %h seen %h", what, exp, got); end end

module nism_top_test
    import nism_pkg::*;
;
    // ------------------------------------------------------------------------
    // Stimulus and observation signals
    // ------------------------------------------------------------------------
    logic             i_clk   = 1'b0;
    logic             i_srst  = 1'b1;
    nism_bus_req_type bus     = '0;
    nism_events_type  ev      = '0;
    logic [2:0]       tally   = 3'h0;
    logic [7:0]       lptr    = 8'h00;
    logic [7:0]       bptr    = 8'h10;
    logic [7:0]       rdata;
    logic [7:0]       flags;
    logic             irq;
    logic [7:0]       v;
    logic [7:0]       exp_f;
    int               errors      = 0;
    int               check_count = 0;
    // Flag bit reached by each of the first nine event pulses
    int               ev_bit [9]  = '{0, 2, 2, 2, 2, 1, 3, 3, 6};

    // Clock at 100 MHz
    always #5 i_clk = ~i_clk;

    nism_top i_nism_top (
        .i_clk           (i_clk),
        .i_srst          (i_srst),
        .i_bus           (bus),
        .o_rdata         (rdata),
        .i_events        (ev),
        .i_tally_msb     (tally),
        .i_local_dma_ptr (lptr),
        .i_boundary_ptr  (bptr),
        .o_irq           (irq),
        .o_flags         (flags)
    );

    // ------------------------------------------------------------------------
    // Bus and event tasks
    // ------------------------------------------------------------------------
    // Event index 0 is the first struct field, rx_ok
    function automatic nism_events_type ev_of(input int idx);
        return nism_events_type'(13'h0001 << (12 - idx));
    endfunction

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    // Read data stand for one cycle only, then fall back to idle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1;
        d = rdata;
        @(posedge i_clk);
        #1;
        `CHECK("read idle", 8'h00, rdata)
    endtask

    // One-cycle event pulse, optionally beside a clear-all write
    task automatic pulse(input nism_events_type e, input logic clr);
        @(posedge i_clk);
        ev <= e;
        if (clr) begin
            bus <= '{addr: `NISM_FLAGS_ADDR, wdata: 8'hFF, wr: 1'b1, rd: 1'b0};
        end
        @(posedge i_clk);
        ev     <= '0;
        bus.wr <= 1'b0;
        #1;
    endtask

    task automatic end_test(input string name);
        $display("test %s finished", name);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        `CHECK("flags after reset", 8'h80, flags)
        `CHECK("irq after reset", 1'b0, irq)
        rd(`NISM_FLAGS_ADDR, v);
        `CHECK("flags read", 8'h80, v)
        rd(`NISM_MASK_ADDR, v);
        `CHECK("mask read", 8'h00, v)
        wr(`NISM_FLAGS_ADDR, 8'hFF);
        `CHECK("bit7 after all-ones write", 8'h80, flags)
        end_test("reset");

        // Each of the first nine event pulses lands on its flag; write zero keeps, write one clears
        wr(`NISM_MASK_ADDR, 8'h7F);
        for (int k = 0; k < 9; k++) begin
            exp_f = 8'h80 | (8'h01 << ev_bit[k]);
            pulse(ev_of(k), 1'b0);
            `CHECK("flag set by event", exp_f, flags)
            `CHECK("irq enabled flag", 1'b1, irq)
            wr(`NISM_FLAGS_ADDR, 8'h00);
            `CHECK("write zero keeps", exp_f, flags)
            wr(`NISM_FLAGS_ADDR, exp_f & 8'h7F);
            `CHECK("write one clears", 8'h80, flags)
            `CHECK("irq after clear", 1'b0, irq)
        end
        @(posedge i_clk);
        tally <= 3'h4;
        repeat (2) @(posedge i_clk);
        #1;
        `CHECK("tally flag", 8'hA0, flags)
        @(posedge i_clk);
        lptr <= 8'h10;
        repeat (2) @(posedge i_clk);
        #1;
        `CHECK("ring full flag", 8'hB0, flags)
        wr(`NISM_FLAGS_ADDR, 8'h30);
        `CHECK("levels set only once", 8'h80, flags)
        end_test("sources");

        // Interrupt holds until the last enabled flag goes
        pulse(ev_of(0), 1'b0);
        pulse(ev_of(5), 1'b0);
        wr(`NISM_FLAGS_ADDR, 8'h01);
        `CHECK("irq one flag left", 1'b1, irq)
        wr(`NISM_FLAGS_ADDR, 8'h02);
        `CHECK("irq none left", 1'b0, irq)
        wr(`NISM_MASK_ADDR, 8'h00);
        pulse(ev_of(1), 1'b0);
        `CHECK("irq masked", 1'b0, irq)
        wr(`NISM_MASK_ADDR, 8'h04);
        `CHECK("irq unmasked late", 1'b1, irq)
        wr(`NISM_MASK_ADDR, 8'h80);
        `CHECK("reserved mask bit", 1'b0, irq)
        wr(`NISM_FLAGS_ADDR, 8'h04);
        pulse(ev_of(0), 1'b1);
        `CHECK("set beats clear", 8'h81, flags)
        wr(`NISM_FLAGS_ADDR, 8'h01);
        end_test("mask");

        // Reset indicator: start, stop, overflow, removal, writes
        wr(`NISM_MASK_ADDR, 8'hFF);
        pulse(ev_of(11), 1'b0);
        `CHECK("start clears bit7", 8'h00, flags)
        pulse(ev_of(12), 1'b0);
        `CHECK("stop sets bit7", 8'h80, flags)
        `CHECK("bit7 no irq", 1'b0, irq)
        pulse(ev_of(11), 1'b0);
        pulse(ev_of(9), 1'b0);
        `CHECK("overflow sets bit7", 8'h80, flags)
        `CHECK("bit7 no irq", 1'b0, irq)
        pulse(ev_of(10), 1'b0);
        `CHECK("removal clears bit7", 8'h00, flags)
        pulse(ev_of(11) | ev_of(12), 1'b0);
        `CHECK("stop beats start", 8'h80, flags)
        wr(`NISM_FLAGS_ADDR, 8'h80);
        `CHECK("bit7 write ignored", 8'h80, flags)
        pulse(ev_of(11), 1'b0);
        `CHECK("start clears bit7", 8'h00, flags)
        end_test("reset_status");

        // Unmapped place, then a reset in mid-run
        pulse(ev_of(0), 1'b0);
        wr(4'h3, 8'hFF);
        `CHECK("unmapped write", 8'h01, flags)
        rd(4'h3, v);
        `CHECK("unmapped read", 8'h00, v)
        @(posedge i_clk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_srst <= 1'b0;
        #1;
        `CHECK("flags after reset", 8'h80, flags)
        `CHECK("irq after reset", 1'b0, irq)
        pulse(ev_of(0), 1'b0);
        `CHECK("mask cleared by reset", 1'b0, irq)
        end_test("mid_reset");
        close_out();
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        #200us;
        errors++;
        close_out();
    end
endmodule
